// ===== fapc_array.sv
`default_nettype none

module fapc_array #(
  parameter int FLASH_BYTES = 8192,
  parameter int AW = 13
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire fapc_pkg::fapc_op_e op,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] rd_addr,
  output logic busy,
  output logic [7:0] rd_data
);

  // Nonvolatile contents carry no reset; erase leaves every byte of the erased page, or of the whole array for mass erase, at the erased value.
  logic [7:0] mem [FLASH_BYTES];
  fapc_pkg::fapc_arr_state_e state_reg, state_next;
  logic [AW-1:0] ptr_reg, ptr_next;
  logic [AW-1:0] last_reg, last_next;
  logic mem_we;
  logic [AW-1:0] mem_addr;
  logic [7:0] mem_data;

  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    last_next = last_reg;
    mem_we = 1'b0;
    mem_addr = addr;
    mem_data = mem[addr] & wdata;
    case (state_reg)
      fapc_pkg::FAPC_IDLE: begin
        if (start) begin
          if (op == fapc_pkg::FAPC_OP_PROG) begin
            mem_we = 1'b1;
          end else begin
            state_next = fapc_pkg::FAPC_ERASE;
            if (op == fapc_pkg::FAPC_OP_MASS) begin
              ptr_next = '0;
              last_next = AW'(FLASH_BYTES - 1);
            end else begin
              ptr_next = {addr[AW-1:fapc_pkg::PAGE_SHIFT], {fapc_pkg::PAGE_SHIFT{1'b0}}};
              last_next = {addr[AW-1:fapc_pkg::PAGE_SHIFT], {fapc_pkg::PAGE_SHIFT{1'b1}}};
            end
          end
        end
      end
      fapc_pkg::FAPC_ERASE: begin
        mem_we = 1'b1;
        mem_addr = ptr_reg;
        mem_data = fapc_pkg::ERASED_BYTE;
        ptr_next = ptr_reg + AW'(1);
        if (ptr_reg == last_reg) begin
          state_next = fapc_pkg::FAPC_IDLE;
        end
      end
      default: state_next = fapc_pkg::FAPC_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= fapc_pkg::FAPC_IDLE;
      ptr_reg <= '0;
      last_reg <= '0;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      last_reg <= last_next;
    end
  end

  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_data;
    end
  end

  assign busy = state_reg == fapc_pkg::FAPC_ERASE;
  assign rd_data = mem[rd_addr];

endmodule : fapc_array

`default_nettype wire

// ===== fapc_asserts.sv
`default_nettype none
module fapc_asserts #(
  parameter int FLASH_BYTES = 8192
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic on_chip_debugger_sel,
  input wire logic flash_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic cmd_w;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  assign cmd_w = psel && penable && pready && pwrite && paddr == fapc_pkg::OFS_CMD;
  // Counts busy cycles so the erase length can be checked beyond what a repetition can unroll.
  always_comb begin
    cnt_next = flash_busy ? cnt_reg + 16'h1 : 16'h0;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  a_ready_delay: assert property ((psel && !penable) |-> ##2 pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_unmapped_err: assert property ((pready && paddr > 8'h18) |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  a_mapped_ok: assert property ((pready && paddr <= 8'h18 && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("mapped refused");
  a_busy_cause: assert property ($rose(flash_busy) |-> $past(cmd_w) || $past(cmd_w, 2))
    else $error("busy without command");
  a_busy_hold: assert property ($rose(flash_busy) |=> flash_busy[*8]) else $error("busy dropped");
  // The flag rises on the starting edge but follows the array on the way down, so it stands one extra cycle.
  a_busy_len: assert property ($fell(flash_busy) |-> cnt_reg == 16'(fapc_pkg::PAGE_BYTES + 1)
    || cnt_reg == 16'(FLASH_BYTES + 1)) else $error("erase length wrong");
  a_mass_sw: assert property ((cmd_w && !on_chip_debugger_sel && !flash_busy
    && pwdata == {30'h0, fapc_pkg::CMD_MASS_ERASE}) |=> !flash_busy[*2]) else $error("sw mass erase ran");
endmodule : fapc_asserts

bind fapc_ctrl fapc_asserts #(.FLASH_BYTES(FLASH_BYTES)) i_fapc_asserts (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .on_chip_debugger_sel(on_chip_debugger_sel), .flash_busy(flash_busy)
);
`default_nettype wire

// ===== fapc_ctrl.sv
`default_nettype none

// Contract
// - Array holds 8192 or 4096 bytes by variant; read, program, erase supported.
// - Processor software or the on-chip debugger may start program and erase.
// - Pages are 512 bytes; a page is the smallest erasable region.
// - Eight equal sectors, each protectable against program and erase.
// - Sectors are contiguous ranges: 1024 bytes large variant, 512 small.
// - Debugger access ignores the write-protect option bit.
// - Debugger access ignores sector protection for program and erase.
// - Debugger may program anywhere, not just within the selected page.
// - Debugger may write each sector-protect bit to one or zero.
// - Debugger unlocks without the second page-select write.
// - Debugger page-select writes take effect while unlocked.
// - Debugger access accepts and performs the mass erase command.
module fapc_ctrl #(
  parameter int FLASH_BYTES = fapc_pkg::FLASH_BYTES_LARGE
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic on_chip_debugger_sel,
  output logic flash_busy
);

  localparam int AW = $clog2(FLASH_BYTES);
  localparam int PW = AW - fapc_pkg::PAGE_SHIFT;

  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic busy_reg, busy_next;
  logic unlocked_reg, unlocked_next;
  logic armed_reg, armed_next;
  logic err_reg, err_next;
  logic wp_reg, wp_next;
  logic [7:0] sect_prot_reg, sect_prot_next;
  logic [PW-1:0] page_reg, page_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic start;
  fapc_pkg::fapc_op_e op;
  logic [AW-1:0] target;
  logic allow;
  logic arr_busy;
  logic [7:0] rd_byte;
  logic access;
  logic wr;
  logic mapped;
  logic [PW-1:0] wpage;

  fapc_guard #(.AW(AW)) guard_i (
    .dbg(on_chip_debugger_sel),
    .unlocked(unlocked_reg),
    .write_protect(wp_reg),
    .sect_prot(sect_prot_reg),
    .page_sel(page_reg),
    .target(target),
    .op(op),
    .allow(allow)
  );

  fapc_array #(.FLASH_BYTES(FLASH_BYTES), .AW(AW)) array_i (
    .clock(clock),
    .rst(rst),
    .start(start),
    .op(op),
    .addr(target),
    .wdata(pwdata[7:0]),
    .rd_addr(addr_reg),
    .busy(arr_busy),
    .rd_data(rd_byte)
  );

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      fapc_pkg::OFS_STATUS, fapc_pkg::OFS_PAGE_SEL, fapc_pkg::OFS_SECT_PROT, fapc_pkg::OFS_OPTION,
      fapc_pkg::OFS_ADDR, fapc_pkg::OFS_DATA, fapc_pkg::OFS_CMD: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // One wait state: the access phase completes on its second cycle.
  always_comb begin
    access = psel && penable && pready_reg;
    wr = access && pwrite;
    mapped = is_mapped(paddr);
    wpage = pwdata[PW-1:0];
    pready_next = psel && penable && !pready_reg;
    pslverr_next = psel && penable && !pready_reg && !mapped;
    prdata_next = prdata_reg;
    if (psel && penable && !pready_reg && !pwrite) begin
      case (paddr)
        fapc_pkg::OFS_STATUS: begin
          prdata_next = '0;
          prdata_next[fapc_pkg::ST_BUSY_BIT] = busy_reg;
          prdata_next[fapc_pkg::ST_UNLOCKED_BIT] = unlocked_reg;
          prdata_next[fapc_pkg::ST_ARMED_BIT] = armed_reg;
          prdata_next[fapc_pkg::ST_ERR_BIT] = err_reg;
          prdata_next[fapc_pkg::ST_DEBUG_BIT] = on_chip_debugger_sel;
        end
        fapc_pkg::OFS_PAGE_SEL: prdata_next = 32'(page_reg);
        fapc_pkg::OFS_SECT_PROT: prdata_next = 32'(sect_prot_reg);
        fapc_pkg::OFS_OPTION: prdata_next = 32'(wp_reg);
        fapc_pkg::OFS_ADDR: prdata_next = 32'(addr_reg);
        fapc_pkg::OFS_DATA: prdata_next = 32'(rd_byte);
        default: prdata_next = '0;
      endcase
    end
  end

  // Command and protection state.
  always_comb begin
    busy_next = arr_busy;
    unlocked_next = unlocked_reg;
    armed_next = armed_reg;
    err_next = err_reg;
    wp_next = wp_reg;
    sect_prot_next = sect_prot_reg;
    page_next = page_reg;
    addr_next = addr_reg;
    start = 1'b0;
    op = fapc_pkg::FAPC_OP_PROG;
    target = addr_reg;
    if (wr && paddr == fapc_pkg::OFS_CMD) begin
      op = pwdata[1:0] == fapc_pkg::CMD_MASS_ERASE ? fapc_pkg::FAPC_OP_MASS : fapc_pkg::FAPC_OP_PAGE;
      target = {page_reg, {fapc_pkg::PAGE_SHIFT{1'b0}}};
    end
    // Any other completed write breaks a pending key sequence.
    if (wr && paddr != fapc_pkg::OFS_PAGE_SEL) begin
      armed_next = 1'b0;
    end
    if (wr) begin
      case (paddr)
        fapc_pkg::OFS_STATUS: begin
          if (pwdata[fapc_pkg::ST_ERR_BIT]) begin
            err_next = 1'b0;
          end
        end
        fapc_pkg::OFS_PAGE_SEL: begin
          if (unlocked_reg) begin
            page_next = wpage;
          end else if (on_chip_debugger_sel) begin
            page_next = wpage;
            unlocked_next = 1'b1;
          end else if (armed_reg && wpage == page_reg) begin
            unlocked_next = 1'b1;
            armed_next = 1'b0;
          end else begin
            page_next = wpage;
            armed_next = 1'b1;
          end
        end
        fapc_pkg::OFS_SECT_PROT: begin
          if (on_chip_debugger_sel) begin
            sect_prot_next = pwdata[7:0];
          end else begin
            // Software can only add protection; removal needs the debugger or a reset.
            sect_prot_next = sect_prot_reg | pwdata[7:0];
          end
        end
        fapc_pkg::OFS_OPTION: wp_next = pwdata[fapc_pkg::OPT_WP_BIT];
        fapc_pkg::OFS_ADDR: addr_next = pwdata[AW-1:0];
        fapc_pkg::OFS_DATA: begin
          if (!arr_busy && allow) begin
            start = 1'b1;
          end else begin
            err_next = 1'b1;
          end
        end
        fapc_pkg::OFS_CMD: begin
          if (pwdata[1:0] == fapc_pkg::CMD_LOCK) begin
            unlocked_next = 1'b0;
          end else if (pwdata[1:0] != 2'h0 && !arr_busy && allow) begin
            start = 1'b1;
            busy_next = 1'b1;
          end else begin
            err_next = 1'b1;
          end
        end
        default: err_next = err_reg;
      endcase
    end
    // A rejected request on any write other than a status write keeps the error flag set.
    if (wr && paddr != fapc_pkg::OFS_STATUS && err_next) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      busy_reg <= 1'b0;
      unlocked_reg <= 1'b0;
      armed_reg <= 1'b0;
      err_reg <= 1'b0;
      wp_reg <= fapc_pkg::OPT_WP_RESET;
      sect_prot_reg <= fapc_pkg::SECT_PROT_RESET;
      page_reg <= '0;
      addr_reg <= '0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      busy_reg <= busy_next;
      unlocked_reg <= unlocked_next;
      armed_reg <= armed_next;
      err_reg <= err_next;
      wp_reg <= wp_next;
      sect_prot_reg <= sect_prot_next;
      page_reg <= page_next;
      addr_reg <= addr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign flash_busy = busy_reg;

endmodule : fapc_ctrl

`default_nettype wire

// ===== fapc_guard.sv
`default_nettype none

module fapc_guard #(
  parameter int AW = 13
) (
  input wire logic dbg,
  input wire logic unlocked,
  input wire logic write_protect,
  input wire logic [7:0] sect_prot,
  input wire logic [AW-fapc_pkg::PAGE_SHIFT-1:0] page_sel,
  input wire logic [AW-1:0] target,
  input wire fapc_pkg::fapc_op_e op,
  output logic allow
);

  logic [fapc_pkg::SECTOR_W-1:0] sector;
  logic [AW-fapc_pkg::PAGE_SHIFT-1:0] page_of_target;
  logic sector_locked;

  always_comb begin
    sector = target[AW-1 -: fapc_pkg::SECTOR_W];
    page_of_target = op == fapc_pkg::FAPC_OP_PAGE ? page_sel : target[AW-1:fapc_pkg::PAGE_SHIFT];
    if (op == fapc_pkg::FAPC_OP_PAGE) begin
      sector = page_sel[AW-fapc_pkg::PAGE_SHIFT-1 -: fapc_pkg::SECTOR_W];
    end
    sector_locked = sect_prot[sector];
    allow = 1'b0;
    if (unlocked) begin
      if (dbg) begin
        allow = 1'b1;
      end else begin
        case (op)
          fapc_pkg::FAPC_OP_PROG: allow = !write_protect && !sector_locked && page_of_target == page_sel;
          fapc_pkg::FAPC_OP_PAGE: allow = !write_protect && !sector_locked;
          default: allow = 1'b0;
        endcase
      end
    end
  end

endmodule : fapc_guard

`default_nettype wire

// ===== fapc_master.sv
`default_nettype none
module fapc_master (
  input wire logic clock,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic on_chip_debugger_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic timed_out;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    on_chip_debugger_sel = 1'b0;
    timed_out = 1'b0;
  end
  task automatic who(input logic dbg);
    on_chip_debugger_sel <= dbg;
  endtask : who
  // Released lines show the inverse of the last value so a stale hold is never mistaken for data.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    timed_out = n >= 50;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clock);
  endtask : xfer
endmodule : fapc_master
`default_nettype wire

// ===== fapc_pkg.sv
`default_nettype none

package fapc_pkg;

  // Array geometry; all but the two variant sizes is shared by every variant.
  localparam int PAGE_BYTES = 512;
  localparam int SECTOR_COUNT = 8;
  localparam int SECTOR_W = 3;
  localparam int PAGE_SHIFT = 9;
  localparam int FLASH_BYTES_LARGE = 8192;
  localparam int FLASH_BYTES_SMALL = 4096;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Register byte offsets on the APB.
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_PAGE_SEL = 8'h04;
  localparam logic [7:0] OFS_SECT_PROT = 8'h08;
  localparam logic [7:0] OFS_OPTION = 8'h0c;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;

  // Status field positions.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_UNLOCKED_BIT = 1;
  localparam int ST_ARMED_BIT = 2;
  localparam int ST_ERR_BIT = 3;
  localparam int ST_DEBUG_BIT = 4;

  // Option field position.
  localparam int OPT_WP_BIT = 0;

  // Reset values.
  localparam logic [7:0] SECT_PROT_RESET = 8'h00;
  localparam logic OPT_WP_RESET = 1'b0;

  // Command codes written to the command register.
  localparam logic [1:0] CMD_PAGE_ERASE = 2'h1;
  localparam logic [1:0] CMD_MASS_ERASE = 2'h2;
  localparam logic [1:0] CMD_LOCK = 2'h3;

  // Operations handed to the array.
  typedef enum logic [1:0] {
    FAPC_OP_PROG = 2'b00,
    FAPC_OP_PAGE = 2'b01,
    FAPC_OP_MASS = 2'b10
  } fapc_op_e;

  typedef enum logic [0:0] {
    FAPC_IDLE = 1'b0,
    FAPC_ERASE = 1'b1
  } fapc_arr_state_e;

endpackage : fapc_pkg

`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FB = fapc_pkg::FLASH_BYTES_SMALL;
  localparam logic [7:0] ST = fapc_pkg::OFS_STATUS;
  localparam logic [7:0] PS = fapc_pkg::OFS_PAGE_SEL;
  localparam logic [7:0] SP = fapc_pkg::OFS_SECT_PROT;
  localparam logic [7:0] OP = fapc_pkg::OFS_OPTION;
  localparam logic [7:0] CM = fapc_pkg::OFS_CMD;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, dbg, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int error_cnt = 0;
  int n_tests = 0;
  always #5 clock = ~clock;
  fapc_ctrl #(.FLASH_BYTES(FB)) i_fapc_ctrl (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .on_chip_debugger_sel(dbg), .flash_busy(busy));
  fapc_master i_fapc_master (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .on_chip_debugger_sel(dbg));
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    i_fapc_master.xfer(w, a, d, r, e);
    if (i_fapc_master.timed_out) begin
      error_cnt++;
      $display("Error %0t: no pready", $time);
      print_verdict();
    end
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    acc(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    acc(1'b0, a, 32'h0, r, e);
    n_tests++;
    if ((r & m) !== x || e !== xe) begin
      error_cnt++;
      $display("Error %0t: at %h read %h err %b", $time, a, r, e);
    end
  endtask : rd
  task automatic peek(input logic [15:0] a, input logic [7:0] x);
    wr(fapc_pkg::OFS_ADDR, {16'h0, a});
    rd(fapc_pkg::OFS_DATA, 32'hff, {24'h0, x}, 1'b0);
  endtask : peek
  // A refused program must leave the erased byte alone and raise the error flag.
  task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic ok);
    wr(fapc_pkg::OFS_ADDR, {16'h0, a});
    wr(fapc_pkg::OFS_DATA, {24'h0, d});
    rd(ST, 32'h8, ok ? 32'h0 : 32'h8, 1'b0);
    wr(ST, 32'h8);
    peek(a, ok ? d : fapc_pkg::ERASED_BYTE);
  endtask : prog
  task automatic idle();
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    n_tests++;
    if (busy !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: erase not flagged busy", $time);
    end
    do begin
      acc(1'b0, ST, 32'h0, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 2000);
    n_tests++;
    if (n >= 2000) begin
      error_cnt++;
      $display("Error %0t: erase never ended", $time);
      print_verdict();
    end
    n_tests++;
    if (busy !== 1'b0) begin
      error_cnt++;
      $display("Error %0t: busy output stuck after erase", $time);
    end
  endtask : idle
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask : reset_dut
  task automatic s_reset();
    rd(SP, 32'hff, 32'h0, 1'b0);
    rd(OP, 32'h1, 32'h0, 1'b0);
    rd(ST, 32'hf, 32'h0, 1'b0);
    rd(8'h1c, 32'hffffffff, 32'h0, 1'b1);
  endtask : s_reset
  task automatic s_debugger();
    i_fapc_master.who(1'b1);
    wr(PS, 32'h2);
    rd(ST, 32'h2, 32'h2, 1'b0);
    wr(CM, 32'h2);
    idle();
    peek(16'(FB - 1), 8'hff);
    prog(16'h0000, 8'h81, 1'b1);
    wr(SP, 32'h2);
    wr(SP, 32'h0);
    rd(SP, 32'hff, 32'h0, 1'b0);
    wr(SP, 32'h2);
    wr(OP, 32'h1);
    prog(16'h0300, 8'h5a, 1'b1);
    wr(PS, 32'h1);
    rd(PS, 32'hff, 32'h1, 1'b0);
    wr(CM, 32'h1);
    idle();
    peek(16'h0300, 8'hff);
    peek(16'h0000, 8'h81);
    wr(CM, 32'h3);
    rd(ST, 32'h2, 32'h0, 1'b0);
  endtask : s_debugger
  task automatic s_software();
    i_fapc_master.who(1'b0);
    wr(CM, 32'h2);
    rd(ST, 32'h9, 32'h8, 1'b0);
    wr(ST, 32'h8);
    wr(SP, 32'h4);
    wr(SP, 32'h0);
    rd(SP, 32'hff, 32'h4, 1'b0);
    wr(PS, 32'h2);
    rd(ST, 32'h6, 32'h4, 1'b0);
    prog(16'h0400, 8'h11, 1'b0);
    // The writes inside the refused program broke the key, so both page-select writes are needed again.
    wr(PS, 32'h2);
    wr(PS, 32'h2);
    rd(ST, 32'h2, 32'h2, 1'b0);
    prog(16'h0400, 8'h11, 1'b0);
    wr(CM, 32'h1);
    rd(ST, 32'h9, 32'h8, 1'b0);
    wr(ST, 32'h8);
    wr(CM, 32'h3);
    wr(PS, 32'h3);
    wr(PS, 32'h3);
    prog(16'h0600, 8'h3c, 1'b1);
    prog(16'h0800, 8'h3c, 1'b0);
    wr(OP, 32'h1);
    prog(16'h0601, 8'h3c, 1'b0);
  endtask : s_software
  initial begin
    reset_dut();
    s_reset();
    s_debugger();
    reset_dut();
    s_software();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
